// [core/nvspc_pkg.sv]
// nvspc_pkg: constants, types and helpers of the nonvolatile self-program block
package nvspc_pkg;
    localparam int DATA_W = 14;
    localparam int ADDR_W = 15;
    localparam int REG_AW = 3;
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_TIME_NS = 2000;

    localparam logic [REG_AW-1:0] OFF_DATA_LOW = 3'h0;
    localparam logic [REG_AW-1:0] OFF_DATA_HIGH = 3'h1;
    localparam logic [REG_AW-1:0] OFF_ADDR_LOW = 3'h2;
    localparam logic [REG_AW-1:0] OFF_ADDR_HIGH = 3'h3;
    localparam logic [REG_AW-1:0] OFF_CONTROL = 3'h4;
    localparam logic [REG_AW-1:0] OFF_UNLOCK = 3'h5;
    localparam logic [REG_AW-1:0] OFF_STATUS = 3'h6;

    localparam int CTL_FLASH = 7;
    localparam int CTL_CFG = 6;
    localparam int CTL_LATCH_ONLY = 5;
    localparam int CTL_ERASE = 4;
    localparam int CTL_FAULT = 3;
    localparam int CTL_PEN = 2;
    localparam int CTL_PGO = 1;
    localparam int CTL_FGO = 0;
    localparam int STS_DONE = 0;

    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [1:0] DATA_HIGH_PAD = 2'h0;
    localparam logic ADDR_HIGH_PAD = 1'b1;
    localparam logic [6:0] STATUS_PAD = 7'h00;
    localparam logic [7:0] REG_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 14'h0000;

    // configuration space, offsets below the implied top address bit
    localparam logic [ADDR_W-1:0] CFG_USER_FIRST = 15'h0000;
    localparam logic [ADDR_W-1:0] CFG_USER_LAST = 15'h0003;
    localparam logic [ADDR_W-1:0] CFG_DEVICE_ID = 15'h0006;
    localparam logic [ADDR_W-1:0] CFG_WORD_FIRST = 15'h0007;
    localparam logic [ADDR_W-1:0] CFG_WORD_LAST = 15'h0008;

    typedef enum logic [2:0] {
        OP_READ,
        OP_LATCH,
        OP_LATCH_PROG,
        OP_ERASE,
        OP_ERASE_WRITE
    } nvspc_op_t;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } nvspc_bus_t;

    typedef struct packed {
        logic valid;
        nvspc_op_t op;
        logic flash;
        logic cfg;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nvspc_mem_cmd_t;

    function automatic logic cfg_writable(input logic [ADDR_W-1:0] a);
        return (a >= CFG_USER_FIRST) && (a <= CFG_USER_LAST);
    endfunction

    function automatic logic cfg_readable(input logic [ADDR_W-1:0] a);
        return cfg_writable(a) || (a == CFG_DEVICE_ID) ||
            ((a >= CFG_WORD_FIRST) && (a <= CFG_WORD_LAST));
    endfunction
endpackage

// [core/nvspc_unlock.sv]
// nvspc_unlock: tracks the ordered two-byte unlock pattern
`timescale 1ns/1ps
`default_nettype none
module nvspc_unlock (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_unlock_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_other_wr,
    input wire logic i_consume,
    output logic o_armed
);
    typedef enum logic [1:0] {
        NVSPC_LOCKED,
        NVSPC_HALF,
        NVSPC_ARMED
    } nvspc_lock_t;
    nvspc_lock_t state_r, state_nxt;
    wire logic is_first = i_unlock_wr && (i_wdata == nvspc_pkg::UNLOCK_FIRST);
    wire logic is_second = i_unlock_wr
        && (i_wdata == nvspc_pkg::UNLOCK_SECOND);

    // a wrong unlock byte or any write outside the unlock and control ports breaks the sequence; a go write uses it up
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            NVSPC_LOCKED: if (is_first) state_nxt = NVSPC_HALF;
            NVSPC_HALF: begin
                if (is_second) state_nxt = NVSPC_ARMED;
                else if (i_unlock_wr || i_other_wr || i_consume)
                    state_nxt = is_first ? NVSPC_HALF : NVSPC_LOCKED;
            end
            NVSPC_ARMED: begin
                if (i_unlock_wr || i_other_wr || i_consume)
                    state_nxt = is_first ? NVSPC_HALF : NVSPC_LOCKED;
            end
            default: state_nxt = NVSPC_LOCKED;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) state_r <= NVSPC_LOCKED;
        else state_r <= state_nxt;
    end

    assign o_armed = (state_r == NVSPC_ARMED);
endmodule
`default_nettype wire

// [core/nvspc_timer.sv]
// nvspc_timer: self-timed program/erase interval counter
`timescale 1ns/1ps
`default_nettype none
module nvspc_timer #(
    parameter int CYCLES = 50
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] ONE = CW'(1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    logic [CW-1:0] count_r;

    if (CYCLES < 1) begin : g_bad
        $error("nvspc_timer needs CYCLES of at least one");
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) count_r <= '0;
        else if (i_start) count_r <= LOAD;
        else if (o_busy) count_r <= count_r - ONE;
    end

    assign o_busy = (count_r != '0);
    assign o_done = (count_r == ONE);
endmodule
`default_nettype wire

// [core/nvspc_ctrl.sv]
// nvspc_ctrl: register file and sequencer for flash/EEPROM self-programming
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: low data register holds eight bits: EEPROM byte or word low bits.
// R2: high data register holds word bits 13:8; its two top bits read zero.
// R3: low address register holds address bits 7:0, cleared on reset.
// R4: high address register holds bits 14:8, cleared on reset; top reads one.
// R5: control bit 7 selects program flash when set, EEPROM when clear.
// R6: control bit 6 redirects accesses to configuration and ID space.
// R7: with latch-only set on flash/config, a go only loads the latches.
// R8: with latch-only clear, a go latches the data then programs all latches.
// R9: EEPROM target ignores latch-only and erase; each go erases then writes.
// R10: erase select makes the go erase; hardware clears it after the erase.
// R11: fault flag sets on each go set attempt and on bad/cut operations.
// R12: with program enable clear, no program or erase cycle is allowed.
// R13: program go starts a timed operation, cleared by hardware; set-only.
// R14: fetch go starts a one-cycle read, then hardware clears it; set-only.
// R15: software should read back each written location and compare.
// R16: a go is accepted only after 55h then AAh written to the unlock port.
// R17: a config read outside the readable set clears both data registers.
// R18: user IDs read/write; device ID and configuration words are read-only.
// R19: the processor stalls while a timed write or erase runs.
// R20: a completed timed operation sets a pollable completion flag.
module nvspc_ctrl #(
    parameter int PROG_TIME_NS = nvspc_pkg::PROG_TIME_NS
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire nvspc_pkg::nvspc_bus_t i_bus,
    output logic [7:0] o_rdata,
    output nvspc_pkg::nvspc_mem_cmd_t o_mem_cmd,
    input wire logic [nvspc_pkg::DATA_W-1:0] i_mem_rdata,
    output logic o_cpu_stall
);
    localparam int PROG_CYC = (PROG_TIME_NS + nvspc_pkg::CLK_PERIOD_NS - 1)
        / nvspc_pkg::CLK_PERIOD_NS;
    localparam int PROG_WAIT = PROG_CYC + 2;

    if (PROG_CYC < 1) begin : g_bad
        $error("nvspc_ctrl needs a program time of at least one cycle");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_LATCH, ST_TIMED} nvspc_st_t;

    nvspc_st_t state_r, state_nxt;
    logic [7:0] data_low_r, data_low_nxt;
    logic [5:0] data_high_r, data_high_nxt;
    logic [7:0] addr_low_r;
    logic [6:0] addr_high_r;
    logic flash_r, cfg_r, latch_only_r, erase_r, fault_r, pen_r;
    logic go_r, fetch_r;
    logic erase_nxt, fault_nxt, go_nxt, fetch_nxt;
    logic done_flag_r;
    logic [7:0] rdata_r;
    nvspc_pkg::nvspc_mem_cmd_t cmd_r, cmd_nxt;
    nvspc_pkg::nvspc_op_t op_r;

    // bus decode
    wire logic [nvspc_pkg::ADDR_W-1:0] nv_address = {addr_high_r, addr_low_r};
    wire logic [nvspc_pkg::DATA_W-1:0] nv_data_word =
        {data_high_r, data_low_r};
    wire logic hit_dlow = i_bus.addr == nvspc_pkg::OFF_DATA_LOW;
    wire logic hit_dhigh = i_bus.addr == nvspc_pkg::OFF_DATA_HIGH;
    wire logic hit_alow = i_bus.addr == nvspc_pkg::OFF_ADDR_LOW;
    wire logic hit_ahigh = i_bus.addr == nvspc_pkg::OFF_ADDR_HIGH;
    wire logic hit_ctl = i_bus.addr == nvspc_pkg::OFF_CONTROL;
    wire logic hit_unlock = i_bus.addr == nvspc_pkg::OFF_UNLOCK;
    wire logic hit_status = i_bus.addr == nvspc_pkg::OFF_STATUS;
    wire logic ctl_wr = i_bus.wr && hit_ctl;
    wire logic go_req = ctl_wr && i_bus.wdata[nvspc_pkg::CTL_PGO] && !go_r;
    wire logic fetch_req = ctl_wr && i_bus.wdata[nvspc_pkg::CTL_FGO];
    wire logic eeprom_sel = !flash_r && !cfg_r;
    wire logic cfg_wr_ok = !cfg_r || nvspc_pkg::cfg_writable(nv_address);
    wire logic armed;
    wire logic accept;
    wire logic fetch_ok;
    wire logic timer_busy;
    wire logic timer_done;
    wire logic timed_op;
    wire logic read_cycle = (state_r == ST_READ);
    wire logic read_zero = cfg_r && !nvspc_pkg::cfg_readable(nv_address);
    wire nvspc_pkg::nvspc_op_t go_op;
    wire logic [7:0] rd_mux;

    nvspc_unlock u_unlock (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_unlock_wr(i_bus.wr && hit_unlock),
        .i_wdata(i_bus.wdata),
        .i_other_wr(i_bus.wr && !hit_unlock && !hit_ctl),
        .i_consume(ctl_wr && i_bus.wdata[nvspc_pkg::CTL_PGO]),
        .o_armed(armed)
    );

    nvspc_timer #(.CYCLES(PROG_CYC)) u_timer (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_start(cmd_r.valid && timed_op),
        .o_busy(timer_busy),
        .o_done(timer_done)
    );

    // go is taken only unlocked, enabled, idle and at a writable address
    assign accept = go_req && armed && pen_r && (state_r == ST_IDLE)
        && cfg_wr_ok; // R12 R16 R18
    assign fetch_ok = fetch_req && !go_r && !fetch_r
        && (state_r == ST_IDLE) && !accept;

    // operation chosen by space and mode bits
    assign go_op = eeprom_sel ? nvspc_pkg::OP_ERASE_WRITE : // R9
        erase_r ? nvspc_pkg::OP_ERASE : // R10
        latch_only_r ? nvspc_pkg::OP_LATCH : // R7
        nvspc_pkg::OP_LATCH_PROG; // R8
    assign timed_op = (cmd_r.op != nvspc_pkg::OP_READ)
        && (cmd_r.op != nvspc_pkg::OP_LATCH);

    assign rd_mux = hit_dlow ? data_low_r : // R1
        hit_dhigh ? {nvspc_pkg::DATA_HIGH_PAD, data_high_r} : // R2
        hit_alow ? addr_low_r :
        hit_ahigh ? {nvspc_pkg::ADDR_HIGH_PAD, addr_high_r} : // R4
        hit_ctl ? {flash_r, cfg_r, latch_only_r, erase_r,
                   fault_r, pen_r, go_r, fetch_r} :
        hit_status ? {nvspc_pkg::STATUS_PAD, done_flag_r} :
        nvspc_pkg::REG_ZERO;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) state_nxt = (go_op == nvspc_pkg::OP_LATCH)
                    ? ST_LATCH : ST_TIMED;
                else if (fetch_ok) state_nxt = ST_READ;
            end
            ST_READ: state_nxt = ST_IDLE; // R14
            ST_LATCH: state_nxt = ST_IDLE;
            ST_TIMED: if (timer_done) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_comb begin
        cmd_nxt = cmd_r;
        cmd_nxt.valid = accept || fetch_ok;
        if (accept || fetch_ok) begin
            cmd_nxt.op = accept ? go_op : nvspc_pkg::OP_READ;
            cmd_nxt.flash = flash_r; // R5
            cmd_nxt.cfg = cfg_r; // R6
            cmd_nxt.addr = nv_address;
            cmd_nxt.data = nv_data_word;
        end
    end

    // read capture beats a bus write landing in the same cycle
    always_comb begin
        data_low_nxt = data_low_r;
        data_high_nxt = data_high_r;
        if (read_cycle) begin
            data_low_nxt = read_zero ? nvspc_pkg::REG_ZERO
                : i_mem_rdata[7:0]; // R17
            data_high_nxt = read_zero ? nvspc_pkg::DATA_RESET[13:8]
                : i_mem_rdata[13:8]; // R17
        end else begin
            if (i_bus.wr && hit_dlow) data_low_nxt = i_bus.wdata;
            if (i_bus.wr && hit_dhigh) data_high_nxt = i_bus.wdata[5:0];
        end
    end

    always_comb begin
        go_nxt = go_r;
        if (accept) go_nxt = 1'b1; // R13
        else if ((state_r == ST_LATCH) || timer_done) go_nxt = 1'b0; // R13
        fetch_nxt = fetch_ok ? 1'b1 : 1'b0; // R14
        erase_nxt = erase_r;
        if (timer_done && (op_r == nvspc_pkg::OP_ERASE)) erase_nxt = 1'b0;
        else if (ctl_wr) erase_nxt = i_bus.wdata[nvspc_pkg::CTL_ERASE];
        // set attempt sets the fault; clean completion clears it
        fault_nxt = fault_r;
        if (go_req) fault_nxt = 1'b1; // R11
        else if (timer_done || (state_r == ST_LATCH)) fault_nxt = 1'b0;
        else if (ctl_wr) fault_nxt = i_bus.wdata[nvspc_pkg::CTL_FAULT];
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= ST_IDLE;
            data_low_r <= nvspc_pkg::DATA_RESET[7:0];
            data_high_r <= nvspc_pkg::DATA_RESET[13:8];
            go_r <= 1'b0;
            fetch_r <= 1'b0;
            erase_r <= 1'b0;
            fault_r <= 1'b0;
            cmd_r <= '0;
            op_r <= nvspc_pkg::OP_READ;
        end else begin
            state_r <= state_nxt;
            data_low_r <= data_low_nxt; // R1
            data_high_r <= data_high_nxt; // R2
            go_r <= go_nxt;
            fetch_r <= fetch_nxt;
            erase_r <= erase_nxt; // R10
            fault_r <= fault_nxt;
            cmd_r <= cmd_nxt;
            if (accept) op_r <= go_op;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            addr_low_r <= nvspc_pkg::ADDR_RESET[7:0]; // R3
            addr_high_r <= nvspc_pkg::ADDR_RESET[14:8]; // R4
        end else begin
            if (i_bus.wr && hit_alow) addr_low_r <= i_bus.wdata; // R3
            if (i_bus.wr && hit_ahigh) addr_high_r <= i_bus.wdata[6:0]; // R4
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flash_r <= 1'b0;
            cfg_r <= 1'b0;
            latch_only_r <= 1'b0;
            pen_r <= 1'b0;
        end else if (ctl_wr) begin
            flash_r <= i_bus.wdata[nvspc_pkg::CTL_FLASH]; // R5
            cfg_r <= i_bus.wdata[nvspc_pkg::CTL_CFG]; // R6
            latch_only_r <= i_bus.wdata[nvspc_pkg::CTL_LATCH_ONLY];
            pen_r <= i_bus.wdata[nvspc_pkg::CTL_PEN]; // R12
        end
    end

    // completion flag: write one to clear, a new completion wins
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) done_flag_r <= 1'b0;
        else if (timer_done) done_flag_r <= 1'b1; // R20
        else if (i_bus.wr && hit_status && i_bus.wdata[nvspc_pkg::STS_DONE])
            done_flag_r <= 1'b0;
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) rdata_r <= nvspc_pkg::REG_ZERO;
        else rdata_r <= i_bus.rd ? rd_mux : nvspc_pkg::REG_ZERO;
    end

    assign o_rdata = rdata_r;
    assign o_mem_cmd = cmd_r;
    assign o_cpu_stall = (state_r == ST_TIMED); // R19

    a_dhigh_top_zero: assert property ( // R2
        @(posedge i_clock) disable iff (i_sys_rst)
        i_bus.rd && hit_dhigh |=> o_rdata[7:6] == 2'h0)
        else $error("high data register top bits not zero");

    a_ahigh_top_one: assert property ( // R4
        @(posedge i_clock) disable iff (i_sys_rst)
        i_bus.rd && hit_ahigh |=> o_rdata[7] == 1'b1)
        else $error("high address register top bit not one");

    a_go_needs_unlock: assert property ( // R16
        @(posedge i_clock) disable iff (i_sys_rst)
        $rose(go_r) |-> $past(armed) && $past(pen_r))
        else $error("program go started without unlock and enable");

    a_go_blocked_pen: assert property ( // R12
        @(posedge i_clock) disable iff (i_sys_rst)
        go_req && !pen_r |=> !go_r && !cmd_r.valid)
        else $error("program go taken while disabled");

    a_fault_on_set: assert property ( // R11
        @(posedge i_clock) disable iff (i_sys_rst)
        go_req |=> fault_r)
        else $error("fault flag not set on go attempt");

    a_fetch_one_cycle: assert property ( // R14
        @(posedge i_clock) disable iff (i_sys_rst)
        fetch_ok |=> fetch_r ##1 !fetch_r)
        else $error("fetch go not cleared after one cycle");

    a_go_self_clear: assert property ( // R13
        @(posedge i_clock) disable iff (i_sys_rst)
        accept |=> go_r ##[1:PROG_WAIT] !go_r)
        else $error("program go not cleared in time");

    // a zero written to the go bit must leave a running go standing
    a_go_set_only: assert property ( // R13
        @(posedge i_clock) disable iff (i_sys_rst)
        go_r && !timer_done && (state_r != ST_LATCH) |=> go_r)
        else $error("program go cleared before completion");

    a_erase_clears: assert property ( // R10
        @(posedge i_clock) disable iff (i_sys_rst)
        timer_done && op_r == nvspc_pkg::OP_ERASE |=> !erase_r)
        else $error("erase select not cleared after erase");

    a_eeprom_erase_write: assert property ( // R9
        @(posedge i_clock) disable iff (i_sys_rst)
        accept && eeprom_sel |=>
            cmd_r.valid && cmd_r.op == nvspc_pkg::OP_ERASE_WRITE)
        else $error("EEPROM go did not erase and write");

    a_latch_no_prog: assert property ( // R7
        @(posedge i_clock) disable iff (i_sys_rst)
        accept && !eeprom_sel && !erase_r && latch_only_r |=>
            cmd_r.op == nvspc_pkg::OP_LATCH ##1 !o_cpu_stall)
        else $error("latch-only go started a program cycle");

    a_cfg_bad_clear: assert property ( // R17
        @(posedge i_clock) disable iff (i_sys_rst)
        read_cycle && read_zero |=> nv_data_word == '0)
        else $error("bad config read did not clear data");

    a_cfg_read_only: assert property ( // R18
        @(posedge i_clock) disable iff (i_sys_rst)
        go_req && cfg_r && !nvspc_pkg::cfg_writable(nv_address) |=> !go_r)
        else $error("write to read-only config location");

    a_stall_timed: assert property ( // R19
        @(posedge i_clock) disable iff (i_sys_rst)
        cmd_r.valid && timed_op |-> o_cpu_stall[*2])
        else $error("processor not stalled during timed operation");

    // the interval counter may only run while the processor is held
    a_timer_in_stall: assert property ( // R19
        @(posedge i_clock) disable iff (i_sys_rst)
        timer_busy |-> o_cpu_stall)
        else $error("timed interval running without a stall");

    a_done_on_finish: assert property ( // R20
        @(posedge i_clock) disable iff (i_sys_rst)
        timer_done |=> done_flag_r)
        else $error("completion flag not set after timed operation");

    c_eeprom_write: cover property (
        @(posedge i_clock) disable iff (i_sys_rst)
        accept && eeprom_sel ##1 o_cpu_stall);

    c_flash_erase: cover property (
        @(posedge i_clock) disable iff (i_sys_rst)
        timer_done && op_r == nvspc_pkg::OP_ERASE);

    c_read: cover property (
        @(posedge i_clock) disable iff (i_sys_rst)
        read_cycle && !read_zero);

    c_refused: cover property (
        @(posedge i_clock) disable iff (i_sys_rst)
        go_req && !accept);
endmodule
`default_nettype wire

// [tb/nvspc_mem_model.sv]
// nvspc_mem_model: behavioural flash, eeprom and config arrays
`timescale 1ns/1ps
`default_nettype none
module nvspc_mem_model (
    input wire logic i_clock,
    input wire nvspc_pkg::nvspc_mem_cmd_t i_cmd,
    output logic [nvspc_pkg::DATA_W-1:0] o_rdata
);
    logic [13:0] mem [logic [16:0]];
    logic [13:0] lat [logic [16:0]];
    logic [16:0] key;
    logic alt = 1'b0;
    assign key = {i_cmd.cfg, i_cmd.flash, i_cmd.addr};
    // outside a read the word keeps changing so no stale value passes
    always_comb begin
        if (i_cmd.valid && i_cmd.op == nvspc_pkg::OP_READ) begin
            o_rdata = mem.exists(key) ? mem[key] : 14'h3FFF;
        end else begin
            o_rdata = {7{alt, ~alt}};
        end
    end
    always @(posedge i_clock) begin
        alt <= ~alt;
        if (i_cmd.valid) begin
            case (i_cmd.op)
                nvspc_pkg::OP_LATCH: lat[key] = i_cmd.data;
                nvspc_pkg::OP_LATCH_PROG: begin
                    lat[key] = i_cmd.data;
                    foreach (lat[k]) mem[k] = lat[k];
                    lat.delete();
                end
                nvspc_pkg::OP_ERASE: mem[key] = 14'h3FFF;
                nvspc_pkg::OP_ERASE_WRITE: mem[key] = i_cmd.data;
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// [tb/nv_memory_self_program_ctrl_tb_top.sv]
// nv_memory_self_program_ctrl_tb_top: register-level bench of nvspc_ctrl
`timescale 1ns/1ps
`default_nettype none
module nv_memory_self_program_ctrl_tb_top;
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    nvspc_pkg::nvspc_bus_t bus = '0;
    logic [7:0] rdata;
    nvspc_pkg::nvspc_mem_cmd_t cmd;
    logic [nvspc_pkg::DATA_W-1:0] mem_rdata;
    logic stall;
    int num_errors = 0;
    int num_checks = 0;
    int n_cmd = 0;

    nvspc_ctrl #(.PROG_TIME_NS(200)) i_nvspc_ctrl (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_bus(bus),
        .o_rdata(rdata), .o_mem_cmd(cmd), .i_mem_rdata(mem_rdata),
        .o_cpu_stall(stall)
    );
    nvspc_mem_model i_nvspc_mem_model (
        .i_clock(i_clock), .i_cmd(cmd), .o_rdata(mem_rdata)
    );

    always #20 i_clock = ~i_clock;
    always @(posedge i_clock) if (cmd.valid === 1'b1) n_cmd <= n_cmd + 1;

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
        bus <= '0;
        #1;
    endtask
    task automatic rd_chk(string what, logic [2:0] a, logic [7:0] exp);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        bus <= '0;
        #1;
        chk(what, {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic go(logic [7:0] ctl);
        // enable and space bits must already stand when the go lands
        wr(3'h4, ctl & 8'hFC);
        wr(3'h5, nvspc_pkg::UNLOCK_FIRST);
        wr(3'h5, nvspc_pkg::UNLOCK_SECOND);
        wr(3'h4, ctl);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 20 && stall !== 1'b0; i++) @(posedge i_clock);
        #1;
        chk("stall end", 16'h0000, {15'h0, stall});
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic t_reset_map();
        rd_chk("addr low", 3'h2, 8'h00);
        rd_chk("addr high", 3'h3, 8'h80);
        rd_chk("control", 3'h4, 8'h00);
        rd_chk("unmapped", 3'h7, 8'h00);
        wr(3'h1, 8'hFF);
        wr(3'h0, 8'hA5);
        wr(3'h3, 8'hFF);
        rd_chk("data high", 3'h1, 8'h3F);
        rd_chk("data low", 3'h0, 8'hA5);
        rd_chk("addr high", 3'h3, 8'hFF);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h21);
        rd_chk("addr low", 3'h2, 8'h21);
    endtask
    task automatic t_refusals();
        wr(3'h4, 8'h82);
        rd_chk("no unlock", 3'h4, 8'h88);
        go(8'h82);
        chk("blocked", 16'h0000, {15'h0, cmd.valid});
        rd_chk("fault", 3'h4, 8'h88);
    endtask
    task automatic t_eeprom();
        go(8'h36);
        chk("op", 16'(nvspc_pkg::OP_ERASE_WRITE), 16'(cmd.op));
        chk("wdata", 16'h3FA5, 16'(cmd.data));
        chk("stall", 16'h0001, {15'h0, stall});
        wr(3'h4, 8'h34);
        rd_chk("go held", 3'h4, 8'h36);
        wait_idle();
        rd_chk("ctl done", 3'h4, 8'h34);
        rd_chk("done flag", 3'h6, 8'h01);
        wr(3'h6, 8'h01);
        rd_chk("done clr", 3'h6, 8'h00);
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h35);
        rd_chk("fetch clr", 3'h4, 8'h34);
        rd_chk("verify", 3'h0, 8'hA5);
    endtask
    task automatic t_flash();
        wr(3'h0, 8'h11);
        go(8'hA6);
        chk("op", 16'(nvspc_pkg::OP_LATCH), 16'(cmd.op));
        chk("flash", 16'h0001, {15'h0, cmd.flash});
        chk("no stall", 16'h0000, {15'h0, stall});
        wr(3'h2, 8'h22);
        go(8'h86);
        chk("op", 16'(nvspc_pkg::OP_LATCH_PROG), 16'(cmd.op));
        chk("addr", 16'h0022, 16'(cmd.addr));
        wait_idle();
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h21);
        wr(3'h4, 8'h85);
        rd_chk("latched", 3'h0, 8'h11);
        go(8'h96);
        chk("op", 16'(nvspc_pkg::OP_ERASE), 16'(cmd.op));
        wait_idle();
        rd_chk("erase clr", 3'h4, 8'h84);
    endtask
    task automatic t_config();
        int n0;
        wr(3'h2, 8'h10);
        wr(3'h0, 8'h5A);
        wr(3'h4, 8'h41);
        rd_chk("cfg low", 3'h0, 8'h00);
        rd_chk("cfg high", 3'h1, 8'h00);
        wr(3'h2, 8'h06);
        n0 = n_cmd;
        go(8'h46);
        // a command would be counted one edge after the go write
        @(posedge i_clock);
        #1;
        chk("dev id", 16'(n0), 16'(n_cmd));
        wr(3'h2, 8'h00);
        go(8'h46);
        chk("cfg", 16'h0001, {15'h0, cmd.cfg});
        @(posedge i_clock);
        #1;
        chk("user id", 16'(n0 + 1), 16'(n_cmd));
        wait_idle();
    endtask

    initial begin
        repeat (3) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_reset_map();
        t_refusals();
        t_eeprom();
        t_flash();
        t_config();
        conclude();
    end
    initial begin
        #(3000 * 40);
        num_errors++;
        $display("wrong value watchdog expected done seen hang");
        conclude();
    end
endmodule
`default_nettype wire
